// ---- rtl/adc_ctrl_pkg.sv ----
// Constants, register map and channel codes for the conversion control.
// Assumes a 50 MHz clock and an 8-bit register port.
//
// What this block does
// - Config four upper nibble bypasses attenuators of single voltage channels.
// - Bit 4 acts on 2.5 V, 5 core, 6 5 V, 7 12 V.
// - Config two bit 4 set stores each single conversion, no averaging.
// - Config two bit 5 set bypasses every voltage input attenuator.
// - Config two bit 6 set leaves round robin for single-channel mode.
// - Single-channel mode converts only the selected channel.
// - Single-channel mode converts the selected input once every 0.7 ms.
// - Single-channel select comes from bits 7:5 of fan one minimum high.
// - Select codes 000..111 map 2.5 V, core, supply, 5 V, 12 V, temps.
// - Writing the select also changes the shared fan limit byte.
// - Results are 10-bit straight binary 0..1023, nominal input gives 768.
// - Five voltage-id input levels read back in register 0x43.
// - The 12 V pin can become a sixth voltage-id input in readback.
// - Averaging on: 0.7 ms per conversion, 16 averaged before storing.
package adc_ctrl_pkg;

  localparam logic [7:0] ADDR_VALUE_BASE = 8'h20;
  localparam logic [7:0] ADDR_VOLTAGE_ID = 8'h43;
  localparam logic [7:0] ADDR_FAN1_MIN_HIGH = 8'h55;
  localparam logic [7:0] ADDR_CONFIG_TWO = 8'h73;
  localparam logic [7:0] ADDR_CONFIG_FOUR = 8'h7D;

  localparam logic [7:0] CONFIG_TWO_RESET = 8'h00;
  localparam logic [7:0] CONFIG_FOUR_RESET = 8'h00;
  localparam logic [7:0] FAN1_MIN_HIGH_RESET = 8'h00;
  localparam logic [1:0] VOLTAGE_ID_CTL_RESET = 2'h0;

  localparam int AVG_OFF_BIT = 4;
  localparam int ALL_BYPASS_BIT = 5;
  localparam int SINGLE_MODE_BIT = 6;
  localparam int BYP_2V5_BIT = 4;
  localparam int BYP_CORE_BIT = 5;
  localparam int BYP_5V_BIT = 6;
  localparam int BYP_12V_BIT = 7;
  localparam int SEL_LSB = 5;
  localparam int SEL_MSB = 7;
  localparam int THRESH_BIT = 6;
  localparam int SIXTH_ID_BIT = 7;
  localparam int ID_SIXTH_POS = 5;

  localparam logic [2:0] CH_2V5 = 3'h0;
  localparam logic [2:0] CH_CORE = 3'h1;
  localparam logic [2:0] CH_SUPPLY = 3'h2;
  localparam logic [2:0] CH_5V = 3'h3;
  localparam logic [2:0] CH_12V = 3'h4;
  localparam logic [2:0] CH_REMOTE1 = 3'h5;
  localparam logic [2:0] CH_LOCAL = 3'h6;
  localparam logic [2:0] CH_REMOTE2 = 3'h7;

  localparam int CODE_W = 10;
  localparam logic [9:0] CODE_MAX = 10'h3FF;
  localparam logic [9:0] CODE_NOMINAL = 10'h300;
  localparam int ACC_W = 14;
  localparam logic [3:0] AVG_LAST = 4'hF;

  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_TIME_NS = 700000;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

endpackage

// ---- rtl/conv_if.sv ----
// Link between register side and conversion sequencer.
// Assumes both ends share clk.
`timescale 1ns/1ns
`default_nettype none
interface conv_if;
  logic start;
  logic [2:0] channel;
  logic done;
  logic [9:0] data;
  logic busy;
  logic [3:0] sampleCnt;
  logic storeEn;
  logic [2:0] storeCh;
  logic [9:0] storeVal;
  logic singleMode;
  logic avgOff;
  logic [2:0] selCh;
  logic skip12v;
  modport seq (input done, data, singleMode, avgOff, selCh, skip12v,
    output start, channel, busy, sampleCnt, storeEn, storeCh, storeVal);
  modport ctl (output done, data, singleMode, avgOff, selCh, skip12v,
    input start, channel, busy, sampleCnt, storeEn, storeCh, storeVal);
endinterface
`default_nettype wire

// ---- rtl/conv_sequencer.sv ----
// Picks channels, paces conversions and averages results.
// Assumes the converter answers each start with one done pulse.
`timescale 1ns/1ns
`default_nettype none
module conv_sequencer
  import adc_ctrl_pkg::*;
#(
  parameter int unsigned CONV_CYC = CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  conv_if.seq cv
);
  typedef enum logic [0:0] {WAIT_S, BUSY_S} seq_state_t;

  seq_state_t state_q;
  logic [TIMER_W-1:0] timer_q;
  logic [2:0] rr_q;
  logic [2:0] ch_q;
  logic [3:0] cnt_q;
  logic [ACC_W-1:0] acc_q;
  logic start_q;
  logic storeEn_q;
  logic [9:0] storeVal_q;

  wire logic [2:0] rrPick;
  wire logic [2:0] pick;
  wire logic [ACC_W-1:0] accSum;
  wire logic lastSample;

  // Pin 21 as sixth id input has no 12 V signal to convert
  assign rrPick = (cv.skip12v && rr_q == CH_12V) ? CH_REMOTE1 : rr_q;
  assign pick = cv.singleMode ? cv.selCh : rrPick;
  assign accSum = acc_q + ACC_W'(cv.data);
  assign lastSample = cv.avgOff || cnt_q == AVG_LAST;
  assign cv.start = start_q;
  assign cv.channel = ch_q;
  assign cv.busy = state_q == BUSY_S;
  assign cv.sampleCnt = cnt_q;
  assign cv.storeEn = storeEn_q;
  assign cv.storeCh = ch_q;
  assign cv.storeVal = storeVal_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= WAIT_S;
      timer_q <= '0;
      rr_q <= CH_2V5;
      ch_q <= CH_2V5;
      cnt_q <= '0;
      acc_q <= '0;
      start_q <= 1'b0;
      storeEn_q <= 1'b0;
      storeVal_q <= '0;
    end else begin
      start_q <= 1'b0;
      storeEn_q <= 1'b0;
      if (timer_q != '0) begin
        timer_q <= timer_q - TIMER_W'(1);
      end
      case (state_q)
        WAIT_S: begin
          if (timer_q == '0) begin
            start_q <= 1'b1;
            ch_q <= pick;
            timer_q <= TIMER_W'(CONV_CYC - 1);
            state_q <= BUSY_S;
            // A channel switch drops a half-built average
            if (pick != ch_q) begin
              cnt_q <= '0;
              acc_q <= '0;
            end
          end
        end
        BUSY_S: begin
          if (cv.done) begin
            state_q <= WAIT_S;
            if (lastSample) begin
              storeEn_q <= 1'b1;
              storeVal_q <= cv.avgOff ? cv.data : accSum[ACC_W-1:4];
              cnt_q <= '0;
              acc_q <= '0;
              if (!cv.singleMode) begin
                rr_q <= ch_q + 3'h1;
              end
            end else begin
              cnt_q <= cnt_q + 4'h1;
              acc_q <= accSum;
            end
          end
        end
        default: state_q <= WAIT_S;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- rtl/adc_channel_conversion_control.sv ----
// Register file and converter control for the monitoring ADC.
// Assumes converter handshake on clk; id pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
module adc_channel_conversion_control
  import adc_ctrl_pkg::*;
#(
  parameter int unsigned CONV_CYC = CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic adcStart,
  output logic [2:0] adcChannel,
  input wire logic adcDone,
  input wire logic [9:0] adcData,
  output logic [4:0] attenBypass,
  input wire logic [4:0] voltageIdPins,
  input wire logic pin12vLevel,
  output logic voltageIdThreshLow,
  output logic sixthIdEnable,
  output logic [7:0] fan1MinHigh
);
  conv_if cv ();

  logic [7:0] conversionConfigTwo_q;
  logic [7:0] configFour_q;
  logic [7:0] fan1MinHigh_q;
  logic [1:0] voltageIdCtl_q;
  logic [7:0] rdData_q;
  logic [4:0] attenBypass_q;
  logic [5:0] idMeta_q;
  logic [5:0] idSync_q;
  logic [CODE_W-1:0] result_q [0:7];

  wire logic wrConfigTwo;
  wire logic wrConfigFour;
  wire logic wrFan1MinHigh;
  wire logic wrVoltageId;
  wire logic rdValue;
  wire logic allBypass;
  wire logic sixthId;
  wire logic [4:0] attenBypass_d;
  wire logic [7:0] idReadback;
  wire logic [9:0] valueSel;
  wire logic [7:0] rdMux;

  assign wrConfigTwo = regWrEn && regAddr == ADDR_CONFIG_TWO;
  assign wrConfigFour = regWrEn && regAddr == ADDR_CONFIG_FOUR;
  assign wrFan1MinHigh = regWrEn && regAddr == ADDR_FAN1_MIN_HIGH;
  assign wrVoltageId = regWrEn && regAddr == ADDR_VOLTAGE_ID;
  assign rdValue = regAddr[7:3] == ADDR_VALUE_BASE[7:3];

  assign allBypass = conversionConfigTwo_q[ALL_BYPASS_BIT];
  assign sixthId = voltageIdCtl_q[1];

  // Supply input always keeps its attenuator unless all are bypassed
  assign attenBypass_d = {5{allBypass}} |
    {configFour_q[BYP_12V_BIT], configFour_q[BYP_5V_BIT], 1'b0,
     configFour_q[BYP_CORE_BIT], configFour_q[BYP_2V5_BIT]};

  // Sixth bit reads zero while the pin measures 12 V
  assign idReadback = {voltageIdCtl_q,
    sixthId & idSync_q[ID_SIXTH_POS], idSync_q[4:0]};

  // Value registers hold the top eight bits of each code
  assign valueSel = result_q[regAddr[2:0]];
  assign rdMux = rdValue ? valueSel[CODE_W-1:2] :
    (regAddr == ADDR_VOLTAGE_ID) ? idReadback :
    (regAddr == ADDR_FAN1_MIN_HIGH) ? fan1MinHigh_q :
    (regAddr == ADDR_CONFIG_TWO) ? conversionConfigTwo_q :
    (regAddr == ADDR_CONFIG_FOUR) ? configFour_q : 8'h00;

  assign cv.done = adcDone;
  assign cv.data = adcData;
  assign cv.singleMode = conversionConfigTwo_q[SINGLE_MODE_BIT];
  assign cv.avgOff = conversionConfigTwo_q[AVG_OFF_BIT];
  assign cv.selCh = fan1MinHigh_q[SEL_MSB:SEL_LSB];
  assign cv.skip12v = sixthId;

  assign regRdData = rdData_q;
  assign adcStart = cv.start;
  assign adcChannel = cv.channel;
  assign attenBypass = attenBypass_q;
  assign voltageIdThreshLow = voltageIdCtl_q[0];
  assign sixthIdEnable = sixthId;
  assign fan1MinHigh = fan1MinHigh_q;

  conv_sequencer #(
    .CONV_CYC(CONV_CYC)
  ) u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .cv(cv)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conversionConfigTwo_q <= CONFIG_TWO_RESET;
      configFour_q <= CONFIG_FOUR_RESET;
      fan1MinHigh_q <= FAN1_MIN_HIGH_RESET;
      voltageIdCtl_q <= VOLTAGE_ID_CTL_RESET;
    end else begin
      if (wrConfigTwo) begin
        conversionConfigTwo_q <= regWrData;
      end
      if (wrConfigFour) begin
        configFour_q <= regWrData;
      end
      // One byte serves both fan limit and channel select
      if (wrFan1MinHigh) begin
        fan1MinHigh_q <= regWrData;
      end
      if (wrVoltageId) begin
        voltageIdCtl_q <= {regWrData[SIXTH_ID_BIT], regWrData[THRESH_BIT]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_q <= 8'h00;
      attenBypass_q <= 5'h00;
      idMeta_q <= 6'h00;
      idSync_q <= 6'h00;
    end else begin
      if (regRdEn) begin
        rdData_q <= rdMux;
      end
      attenBypass_q <= attenBypass_d;
      idMeta_q <= {pin12vLevel, voltageIdPins};
      idSync_q <= idMeta_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_result
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          result_q[gi] <= '0;
        end else if (cv.storeEn && cv.storeCh == 3'(gi)) begin
          result_q[gi] <= cv.storeVal;
        end
      end
    end
  endgenerate

  // Helper: cycles since the previous start, for pacing checks
  logic [TIMER_W-1:0] gap_q;
  logic startSeen_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_q <= '0;
      startSeen_q <= 1'b0;
    end else if (cv.start) begin
      gap_q <= '0;
      startSeen_q <= 1'b1;
    end else if (gap_q != '1) begin
      gap_q <= gap_q + TIMER_W'(1);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence idRead;
    regRdEn && regAddr == ADDR_VOLTAGE_ID;
  endsequence

  sequence lastAvgSample;
    cv.busy && cv.done && !cv.avgOff && cv.sampleCnt == AVG_LAST;
  endsequence

  sequence earlyAvgSample;
    cv.busy && cv.done && !cv.avgOff && cv.sampleCnt != AVG_LAST;
  endsequence

  AST_BYPASS_ONE: assert property (
    wrConfigFour && regWrData[BYP_12V_BIT] |-> ##2 attenBypass_q[4])
    else $error("12 V bypass bit did not reach the attenuator");

  AST_BYPASS_MAP: assert property (
    !allBypass && $stable(configFour_q) |=>
      attenBypass_q[1] == $past(configFour_q[BYP_CORE_BIT]) &&
      !attenBypass_q[2])
    else $error("Per-channel bypass bit drives the wrong input");

  AST_BYPASS_ALL: assert property (
    allBypass |=> attenBypass_q == 5'h1F)
    else $error("Global bypass left an attenuator in circuit");

  AST_AVG_OFF: assert property (
    cv.busy && cv.done && cv.avgOff |=>
      cv.storeEn && cv.storeVal == $past(adcData))
    else $error("Unaveraged conversion not stored directly");

  AST_AVG_HOLD: assert property (
    earlyAvgSample |=> !cv.storeEn)
    else $error("Average stored before sixteen samples");

  AST_AVG_STORE: assert property (
    lastAvgSample |=> cv.storeEn)
    else $error("Sixteenth sample did not store the average");

  AST_SINGLE_CH: assert property (
    cv.start && $past(cv.singleMode) && $stable(fan1MinHigh_q) |->
      cv.channel == fan1MinHigh_q[SEL_MSB:SEL_LSB])
    else $error("Single mode converted an unselected channel");

  AST_PACE: assert property (
    cv.start && startSeen_q |-> gap_q >= TIMER_W'(CONV_CYC - 1))
    else $error("Conversions started faster than the pacing period");

  AST_SKIP_12V: assert property (
    cv.start && !$past(cv.singleMode) && $past(sixthId) |->
      cv.channel != CH_12V)
    else $error("12 V converted while its pin is an id input");

  AST_RESULT: assert property (
    cv.storeEn |=> result_q[$past(cv.storeCh)] == $past(cv.storeVal))
    else $error("Stored code did not land in its value register");

  AST_ID_READ: assert property (
    idRead |=> rdData_q[4:0] == $past(idSync_q[4:0]))
    else $error("Id readback differs from synchronised pins");

  AST_ID_SIXTH: assert property (
    idRead and !sixthId |=> !rdData_q[ID_SIXTH_POS])
    else $error("Sixth id bit not zero in 12 V mode");

  AST_SHARED: assert property (
    wrFan1MinHigh |=> fan1MinHigh == $past(regWrData))
    else $error("Select write did not update the shared limit byte");

  // Store in round robin must point the pick at the next channel
  AST_RESUME: assert property (
    cv.storeEn && !cv.singleMode && $stable(cv.singleMode) |->
      u_seq.rr_q == cv.storeCh + 3'h1)
    else $error("Round robin did not resume");

  AST_BYPASS_2V5: assert property (
    !allBypass |=> attenBypass_q[0] == $past(configFour_q[BYP_2V5_BIT]))
    else $error("2.5 V bypass bit drives the wrong input");

  AST_BYPASS_5V: assert property (
    !allBypass |=> attenBypass_q[3] == $past(configFour_q[BYP_5V_BIT]))
    else $error("5 V bypass bit drives the wrong input");

  AST_BYPASS_12V: assert property (
    !allBypass |=> attenBypass_q[4] == $past(configFour_q[BYP_12V_BIT]))
    else $error("12 V bypass bit drives the wrong input");

  AST_CFG2_WRITE: assert property (
    wrConfigTwo |=> conversionConfigTwo_q == $past(regWrData))
    else $error("Config two write did not land");

  AST_CFG4_WRITE: assert property (
    wrConfigFour |=> configFour_q == $past(regWrData))
    else $error("Config four write did not land");

  AST_AVG_COUNT: assert property (
    earlyAvgSample |=> cv.sampleCnt == $past(cv.sampleCnt) + 4'h1)
    else $error("Averaging sample count did not advance");

  AST_START_PULSE: assert property (
    cv.start |=> !cv.start)
    else $error("Convert start held longer than one cycle");

  AST_CH_HOLD: assert property (
    !cv.start |-> $stable(cv.channel))
    else $error("Channel changed without a start");

  AST_NO_STORE_IDLE: assert property (
    !cv.busy |=> !cv.storeEn)
    else $error("Result stored without a conversion");

  AST_RD_HOLD: assert property (
    !regRdEn |=> $stable(rdData_q))
    else $error("Read data changed without a read strobe");

  AST_ID_THRESH: assert property (
    wrVoltageId |=> voltageIdThreshLow == $past(regWrData[THRESH_BIT]))
    else $error("Threshold bit write did not land");

  AST_ID_SEL: assert property (
    wrVoltageId |=> sixthIdEnable == $past(regWrData[SIXTH_ID_BIT]))
    else $error("Sixth id select write did not land");

  AST_ID_SIXTH_ON: assert property (
    idRead and sixthId |=>
      rdData_q[ID_SIXTH_POS] == $past(idSync_q[ID_SIXTH_POS]))
    else $error("Sixth id bit does not follow its pin");

  AST_VALUE_READ: assert property (
    regRdEn && rdValue |=> rdData_q == $past(valueSel[CODE_W-1:2]))
    else $error("Value register read returned the wrong code");

endmodule
`default_nettype wire

// ---- testbench/adc_channel_conversion_control_tb_top.sv ----
// Self-checking bench for the conversion control block.
// Assumes the bench stands in for the converter and the register host.
`timescale 1ns/1ns
`default_nettype none
module adc_channel_conversion_control_tb_top;
  import adc_ctrl_pkg::*;
  localparam int CYC = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic adcStart;
  logic [2:0] adcChannel;
  logic adcDone = 1'b0;
  logic [9:0] adcData = 10'h000;
  logic [4:0] attenBypass;
  logic [4:0] voltageIdPins = 5'h00;
  logic pin12vLevel = 1'b0;
  logic voltageIdThreshLow;
  logic sixthIdEnable;
  logic [7:0] fan1MinHigh;
  int nFail = 0;
  int nTests = 0;
  int cyc = 0;
  int nStarts = 0;
  int nDones = 0;
  int lastStart = 0;
  int wt = 0;
  int dataMode = 0;
  int nSame = 0;
  bit mAvgOff = 1'b0;
  bit skip = 1'b1;
  bit mSingle = 1'b0;
  bit mSixth = 1'b0;
  bit tgl = 1'b0;
  logic [2:0] mSel = 3'h0;
  logic [2:0] prevCh = 3'h0;
  logic [2:0] curCh = 3'h0;
  logic [9:0] fixA = 10'h000;
  logic [9:0] fixB = 10'h000;
  logic [9:0] lastData [8];
  logic [7:0] rv;
  logic [7:0] f;
  logic [3:0] n;
  logic [4:0] id;

  adc_channel_conversion_control #(.CONV_CYC(CYC)) u_dut (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .adcStart(adcStart), .adcChannel(adcChannel), .adcDone(adcDone),
    .adcData(adcData), .attenBypass(attenBypass),
    .voltageIdPins(voltageIdPins), .pin12vLevel(pin12vLevel),
    .voltageIdThreshLow(voltageIdThreshLow),
    .sixthIdEnable(sixthIdEnable), .fan1MinHigh(fan1MinHigh)
  );

  always #10 clk = ~clk;

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    nTests++;
    if (g !== e) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic stopTest();
    $display("Checks %0d, failures %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask

  // Read data holds until the next strobe, so sample a cycle late
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    @(negedge clk);
    d = regRdData;
  endtask

  task automatic rdChk(input string what, input logic [7:0] a,
                       input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(what, {8'h00, e}, {8'h00, d});
  endtask

  task automatic waitEv(input bit dones, input int cnt);
    int tgt;
    int g;
    tgt = (dones ? nDones : nStarts) + cnt;
    g = 0;
    while ((dones ? nDones : nStarts) < tgt && g < 3000) begin
      @(negedge clk);
      g++;
    end
    if (g >= 3000) begin
      chk("wait", 16'h0000, 16'h0001);
    end
  endtask

  function automatic logic [2:0] nextRr(input logic [2:0] p);
    logic [2:0] c;
    c = p + 3'h1;
    if (c == CH_12V && mSixth) begin
      c = CH_REMOTE1;
    end
    return c;
  endfunction

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      nFail++;
      stopTest();
    end
  end

  // Converter stand-in: one done per start, after a random delay
  always @(negedge clk) begin
    adcDone = 1'b0;
    if (adcStart === 1'b1) begin
      if (nStarts > 0) begin
        chk("interval", 16'(CYC), 16'(cyc - lastStart));
      end
      lastStart = cyc;
      nStarts++;
      if (skip) begin
        skip = 1'b0;
      end else if (mSingle) begin
        chk("channel", {13'h0, mSel}, {13'h0, adcChannel});
      end else if (!mAvgOff && nSame < 16) begin
        chk("channel", {13'h0, prevCh}, {13'h0, adcChannel});
      end else begin
        chk("channel", {13'h0, nextRr(prevCh)}, {13'h0, adcChannel});
      end
      if (adcChannel !== prevCh) begin
        nSame = 0;
      end
      prevCh = adcChannel;
      curCh = adcChannel;
      wt = 1 + $urandom % 5;
    end else if (wt > 0) begin
      wt--;
      if (wt == 0) begin
        tgl = ~tgl;
        adcData = (dataMode == 0) ? 10'($urandom % 1024) :
                  (dataMode == 2 && tgl) ? fixB : fixA;
        adcDone = 1'b1;
        lastData[curCh] = adcData;
        nSame++;
        nDones++;
      end
    end
  end

  initial begin
    void'($urandom(10));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    rdChk("cfg2 reset", ADDR_CONFIG_TWO, CONFIG_TWO_RESET);
    rdChk("cfg4 reset", ADDR_CONFIG_FOUR, CONFIG_FOUR_RESET);
    rdChk("fan1 reset", ADDR_FAN1_MIN_HIGH, FAN1_MIN_HIGH_RESET);
    rdChk("id reset", ADDR_VOLTAGE_ID, 8'h00);
    chk("bypass reset", 16'h0000, {11'h0, attenBypass});
    wr(8'h00, 8'h5A);
    rdChk("unmapped", 8'h00, 8'h00);
    for (int i = 0; i < 5; i++) begin
      n = (i == 0) ? 4'hF : 4'($urandom);
      wr(ADDR_CONFIG_FOUR, {n, 4'h0});
      @(negedge clk);
      chk("bypass", {11'h0, n[3], n[2], 1'b0, n[1], n[0]},
          {11'h0, attenBypass});
      rd(ADDR_CONFIG_FOUR, rv);
      chk("cfg4", {12'h0, n}, {12'h0, rv[7:4]});
    end
    wr(ADDR_CONFIG_FOUR, 8'h00);
    wr(ADDR_CONFIG_TWO, 8'h20);
    @(negedge clk);
    chk("all bypass", 16'h001F, {11'h0, attenBypass});
    // Id readback, with the 12 V pin as a sixth input and not
    id = 5'($urandom);
    voltageIdPins = id;
    pin12vLevel = 1'b1;
    repeat (4) @(negedge clk);
    rdChk("id five", ADDR_VOLTAGE_ID, {3'h0, id});
    wr(ADDR_VOLTAGE_ID, 8'hFF);
    // Starts launched from here on see the new pin role
    @(posedge clk);
    mSixth = 1'b1;
    repeat (4) @(negedge clk);
    chk("thresh", 16'h0001, {15'h0, voltageIdThreshLow});
    chk("sixth", 16'h0001, {15'h0, sixthIdEnable});
    rdChk("id six", ADDR_VOLTAGE_ID, {3'h7, id});
    pin12vLevel = 1'b0;
    repeat (4) @(negedge clk);
    rdChk("id six low", ADDR_VOLTAGE_ID, {3'h6, id});
    // Round robin skips the 12 V channel while it serves as an id input
    skip = 1'b1;
    mAvgOff = 1'b1;
    wr(ADDR_CONFIG_TWO, 8'h10);
    waitEv(1'b0, 10);
    // Single channel, averaging off, every select code
    mSingle = 1'b1;
    dataMode = 1;
    for (int s = 0; s < 8; s++) begin
      mSel = 3'(s);
      fixA = (s == 0) ? CODE_MAX : (s == 1) ? CODE_NOMINAL :
             (s == 2) ? 10'h000 : 10'($urandom % 1024);
      f = {mSel, 5'($urandom)};
      skip = 1'b1;
      wr(ADDR_FAN1_MIN_HIGH, f);
      if (s == 0) begin
        wr(ADDR_CONFIG_TWO, 8'h50);
      end
      chk("fan limit", {8'h0, f}, {8'h0, fan1MinHigh});
      rdChk("fan rd", ADDR_FAN1_MIN_HIGH, f);
      waitEv(1'b0, 3);
      waitEv(1'b1, 1);
      repeat (2) @(negedge clk);
      rdChk("value", ADDR_VALUE_BASE + 8'(s), lastData[s][9:2]);
    end
    rdChk("cfg2", ADDR_CONFIG_TWO, 8'h50);
    // Averaging on: alternate codes so one stored sample cannot match
    dataMode = 2;
    mSel = CH_CORE;
    fixA = 10'h100;
    fixB = 10'(($urandom % 512) + 256);
    skip = 1'b1;
    wr(ADDR_FAN1_MIN_HIGH, {CH_CORE, 5'h00});
    wr(ADDR_CONFIG_TWO, 8'h40);
    waitEv(1'b1, 32);
    repeat (2) @(negedge clk);
    rdChk("average", ADDR_VALUE_BASE + 8'h01,
          8'(((8 * fixA + 8 * fixB) >> 4) >> 2));
    // Leaving single mode brings back round robin over all channels
    dataMode = 0;
    wr(ADDR_VOLTAGE_ID, 8'h00);
    wr(ADDR_CONFIG_TWO, 8'h10);
    @(posedge clk);
    mSingle = 1'b0;
    mSixth = 1'b0;
    skip = 1'b1;
    waitEv(1'b0, 12);
    stopTest();
  end
endmodule
`default_nettype wire
